// ### rtl/dioam_param_scan.sv
// Round-robin access to drive parameters for programmable assembly words
`timescale 1ns/1ps
module dioam_param_scan import dioam_pkg::*; #(
  parameter int NMAP = NUM_MAP
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [9:0]  in_map [NMAP],
  input  wire logic [9:0]  out_map [NMAP],
  input  wire logic [2:0]  n_words,
  input  wire logic        wr_req,
  input  wire logic [15:0] wr_data [NMAP],
  input  wire logic [15:0] par_rd_data,
  output logic      [15:0] rd_val [NMAP],
  output logic      [9:0]  par_rd_num,
  output logic             par_wr_en,
  output logic      [9:0]  par_wr_num,
  output logic      [15:0] par_wr_data
);

  localparam int SW = (NMAP > 1) ? $clog2(NMAP) : 1;

  logic [SW-1:0] slot;
  logic [SW-1:0] rd_slot;
  logic [NMAP-1:0] pend;
  logic [15:0]     wdat [NMAP];

  // ==========================================================================
  // Slot sequencing and parameter read
  // ==========================================================================
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slot       <= '0;
      rd_slot    <= '0;
      par_rd_num <= MAP_RESET;
    end else begin
      slot       <= (slot == SW'(NMAP - 1)) ? '0 : slot + 1'b1;
      rd_slot    <= slot;
      par_rd_num <= in_map[slot];
    end
  end

  // ==========================================================================
  // Per-slot read capture and write queue
  // ==========================================================================
  for (genvar i = 0; i < NMAP; i++) begin : g_slot
    wire logic present = (3'(i) + FIXED_WORDS + 3'h1) <= n_words;

    // Disabled or absent word reads as zero; word count stays fixed
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        rd_val[i] <= 16'h0000;
      end else if (rd_slot == SW'(i)) begin
        rd_val[i] <= (present && in_map[i] != MAP_RESET) ? par_rd_data : 16'h0000;
      end
    end

    // New frame sets pending even in the cycle it is being issued
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        pend[i] <= 1'b0;
        wdat[i] <= 16'h0000;
      end else begin
        if (wr_req && present && out_map[i] != MAP_RESET) begin
          pend[i] <= 1'b1;
          wdat[i] <= wr_data[i];
        end else if (slot == SW'(i)) begin
          pend[i] <= 1'b0;
        end
      end
    end
  end

  // ==========================================================================
  // Parameter write issue
  // ==========================================================================
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      par_wr_en   <= 1'b0;
      par_wr_num  <= MAP_RESET;
      par_wr_data <= 16'h0000;
    end else begin
      par_wr_en   <= pend[slot];
      par_wr_num  <= out_map[slot];
      par_wr_data <= wdat[slot];
    end
  end

endmodule // dioam_param_scan

// ### rtl/dioam_pkg.sv
// Constants and types shared by the drive I/O assembly mapper
package dioam_pkg;

  // ==========================================================================
  // Register map (byte addresses on APB)
  // ==========================================================================
  localparam int          APB_AW        = 8;
  localparam logic [7:0]  OFS_STATUS    = 8'h00;
  localparam logic [7:0]  OFS_CMD       = 8'h04;
  localparam logic [7:0]  OFS_IN_MAP0   = 8'h08;
  localparam logic [7:0]  OFS_OUT_MAP0  = 8'h18;
  localparam logic [7:0]  MAP_STRIDE    = 8'h04;

  // ==========================================================================
  // Assembly layouts and word counts
  // ==========================================================================
  localparam logic [2:0]  LAYOUT_BASIC  = 3'h0;
  localparam logic [2:0]  LAYOUT_EXT    = 3'h1;
  localparam logic [2:0]  LAYOUT_MS2    = 3'h2;
  localparam logic [2:0]  LAYOUT_MS3    = 3'h3;
  localparam logic [2:0]  LAYOUT_MS6    = 3'h6;
  localparam logic [2:0]  LAYOUT_RESET  = 3'h0;
  localparam logic [2:0]  FIXED_WORDS   = 3'h2;
  localparam int          MAX_WORDS     = 6;
  localparam int          NUM_MAP       = 4;

  // ==========================================================================
  // Parameter mapping settings
  // ==========================================================================
  localparam logic [9:0]  MAP_MAX       = 10'h3bf;
  localparam logic [9:0]  MAP_RESET     = 10'h000;

  // ==========================================================================
  // Bit positions in byte 0 of the input assembly
  // ==========================================================================
  localparam int          IN_FAULT      = 0;
  localparam int          IN_ALARM      = 1;
  localparam int          IN_FWD        = 2;
  localparam int          IN_REV        = 3;
  localparam int          IN_READY      = 4;
  localparam int          IN_CTRL_NET   = 5;
  localparam int          IN_REF_NET    = 6;
  localparam int          IN_AT_SPEED   = 7;

  // ==========================================================================
  // Bit positions in byte 0 of the output assembly
  // ==========================================================================
  localparam int          OUT_RUN_FWD   = 0;
  localparam int          OUT_RUN_REV   = 1;
  localparam int          OUT_FRESET    = 2;
  localparam int          OUT_NET_CTRL  = 5;
  localparam int          OUT_NET_REF   = 6;

  // ==========================================================================
  // Drive state codes carried in input byte 1
  // ==========================================================================
  typedef enum logic [2:0] {
    DIOAM_NONEXISTENT = 3'b000,
    DIOAM_STARTUP     = 3'b001,
    DIOAM_NOT_READY   = 3'b010,
    DIOAM_READY       = 3'b011,
    DIOAM_ENABLED     = 3'b100,
    DIOAM_STOPPING    = 3'b101,
    DIOAM_FAULT_STOP  = 3'b110,
    DIOAM_FAULTED     = 3'b111
  } dioam_state_t;

endpackage

// ### rtl/dioam_top.sv
// Drive I/O assembly mapper: packs input and unpacks output assemblies
//
// The APB slave port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
module dioam_top import dioam_pkg::*; #(
  parameter int NMAP = NUM_MAP
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [APB_AW-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Layout from nonvolatile setting, sampled once after reset
  input  wire logic [2:0]        cfg_layout_select,
  // Drive status
  input  wire logic              drv_fault,
  input  wire logic              drv_alarm,
  input  wire logic              drv_turn_fwd,
  input  wire logic              drv_turn_rev,
  input  wire logic [2:0]        drv_state,
  input  wire logic              drv_remote,
  input  wire logic              drv_ref_net,
  input  wire logic              drv_at_speed,
  input  wire logic [15:0]       drv_speed_actual,
  // Network side
  input  wire logic              rx_valid,
  input  wire logic [95:0]       rx_data,
  output logic      [95:0]       tx_data,
  output logic      [2:0]        tx_words,
  // Commands to the drive
  output logic                   cmd_run_fwd,
  output logic                   cmd_run_rev,
  output logic                   cmd_fault_reset,
  output logic                   cmd_remote_control,
  output logic                   cmd_remote_setpoint,
  output logic      [15:0]       cmd_speed_ref,
  // Drive parameter access
  output logic      [9:0]        par_rd_num,
  input  wire logic [15:0]       par_rd_data,
  output logic                   par_wr_en,
  output logic      [9:0]        par_wr_num,
  output logic      [15:0]       par_wr_data
);

  logic [2:0]  assembly_layout_select;
  logic        started;
  logic [2:0]  n_words;
  logic [9:0]  in_map  [NMAP];
  logic [9:0]  out_map [NMAP];
  logic [15:0] rd_val  [NMAP];
  logic [15:0] wr_words [NMAP];
  logic [95:0] next_tx_data;
  logic [7:0]  in_flags;
  logic        ready_flag;
  logic        wr_req;
  logic [7:0]  rx_cmd;
  logic [15:0] rx_speed;

  // ==========================================================================
  // Layout latch at startup
  // ==========================================================================
  // Later changes of the setting are ignored until the next reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      started                <= 1'b0;
      assembly_layout_select <= LAYOUT_RESET;
    end else if (!started) begin
      started <= 1'b1;
      if (cfg_layout_select > LAYOUT_MS6) begin
        assembly_layout_select <= LAYOUT_RESET;
      end else begin
        assembly_layout_select <= cfg_layout_select;
      end
    end
  end

  always_comb begin
    if (assembly_layout_select < LAYOUT_MS2) begin
      n_words = FIXED_WORDS;
    end else begin
      n_words = assembly_layout_select;
    end
  end

  // ==========================================================================
  // APB slave
  // ==========================================================================
  logic        apb_acc;
  logic        apb_commit;
  logic [31:0] next_prdata;
  logic        next_pslverr;
  logic [NMAP-1:0] hit_in;
  logic [NMAP-1:0] hit_out;
  logic        val_ok;

  assign apb_acc    = psel & penable & ~pready;
  assign apb_commit = psel & penable & pready & pwrite;
  assign val_ok     = pwdata <= 32'(MAP_MAX);

  for (genvar i = 0; i < NMAP; i++) begin : g_hit
    assign hit_in[i]  = paddr == OFS_IN_MAP0 + MAP_STRIDE * 8'(i);
    assign hit_out[i] = paddr == OFS_OUT_MAP0 + MAP_STRIDE * 8'(i);
  end

  always_comb begin
    next_prdata  = 32'h0000_0000;
    next_pslverr = 1'b0;
    if (paddr == OFS_STATUS) begin
      next_prdata = {22'h000000, drv_state, started, n_words, assembly_layout_select};
    end else if (paddr == OFS_CMD) begin
      next_prdata = {cmd_speed_ref, 11'h000, cmd_remote_setpoint, cmd_remote_control,
                     cmd_fault_reset, cmd_run_rev, cmd_run_fwd};
    end else if (|hit_in || |hit_out) begin
      for (int k = 0; k < NMAP; k++) begin
        if (hit_in[k]) begin
          next_prdata = {22'h000000, in_map[k]};
        end
        if (hit_out[k]) begin
          next_prdata = {22'h000000, out_map[k]};
        end
      end
      next_pslverr = pwrite & ~val_ok;
    end else begin
      next_pslverr = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= apb_acc;
      pslverr <= apb_acc & next_pslverr;
      if (apb_acc && !pwrite) begin
        prdata <= next_prdata;
      end
    end
  end

  // ==========================================================================
  // Mapping settings
  // ==========================================================================
  for (genvar i = 0; i < NMAP; i++) begin : g_map
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        in_map[i]  <= MAP_RESET;
        out_map[i] <= MAP_RESET;
      end else if (apb_commit && val_ok) begin
        if (hit_in[i]) begin
          in_map[i] <= pwdata[9:0];
        end
        if (hit_out[i]) begin
          out_map[i] <= pwdata[9:0];
        end
      end
    end
    assign wr_words[i] = rx_data[16*(i+2) +: 16];
  end

  // ==========================================================================
  // Input assembly
  // ==========================================================================
  always_comb begin
    ready_flag = (drv_state == DIOAM_READY) || (drv_state == DIOAM_ENABLED) ||
                 (drv_state == DIOAM_STOPPING);
    in_flags              = 8'h00;
    in_flags[IN_FAULT]    = drv_fault;
    in_flags[IN_ALARM]    = drv_alarm;
    in_flags[IN_FWD]      = drv_turn_fwd;
    in_flags[IN_REV]      = drv_turn_rev;
    in_flags[IN_READY]    = ready_flag;
    in_flags[IN_CTRL_NET] = drv_remote;
    in_flags[IN_REF_NET]  = drv_ref_net;
    in_flags[IN_AT_SPEED] = drv_at_speed;
  end

  always_comb begin
    next_tx_data = 96'h0;
    if (assembly_layout_select == LAYOUT_BASIC) begin
      next_tx_data[IN_FAULT] = in_flags[IN_FAULT];
      next_tx_data[IN_FWD]   = in_flags[IN_FWD];
    end else begin
      next_tx_data[7:0]  = in_flags;
      next_tx_data[15:8] = {5'h00, drv_state};
    end
    next_tx_data[23:16] = drv_speed_actual[7:0];
    next_tx_data[31:24] = drv_speed_actual[15:8];
    for (int k = 0; k < NMAP; k++) begin
      next_tx_data[16*(k+2) +: 16] = rd_val[k];
    end
  end

  // Refreshed every cycle from current drive status
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_data  <= 96'h0;
      tx_words <= FIXED_WORDS;
    end else begin
      tx_data  <= next_tx_data;
      tx_words <= n_words;
    end
  end

  // ==========================================================================
  // Output assembly decode
  // ==========================================================================
  assign rx_cmd   = rx_data[7:0];
  assign rx_speed = {rx_data[31:24], rx_data[23:16]};
  assign wr_req   = rx_valid && started && assembly_layout_select >= LAYOUT_MS3;

  // Reserved and unused command bits are never looked at
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_run_fwd         <= 1'b0;
      cmd_run_rev         <= 1'b0;
      cmd_remote_control  <= 1'b0;
      cmd_remote_setpoint <= 1'b0;
      cmd_speed_ref       <= 16'h0000;
    end else if (rx_valid && started) begin
      cmd_run_fwd   <= rx_cmd[OUT_RUN_FWD];
      cmd_speed_ref <= rx_speed;
      if (assembly_layout_select == LAYOUT_BASIC) begin
        cmd_run_rev         <= 1'b0;
        cmd_remote_control  <= 1'b0;
        cmd_remote_setpoint <= 1'b0;
      end else begin
        cmd_run_rev         <= rx_cmd[OUT_RUN_REV];
        cmd_remote_control  <= rx_cmd[OUT_NET_CTRL];
        cmd_remote_setpoint <= rx_cmd[OUT_NET_REF];
      end
    end
  end

  // One-cycle request per frame carrying a one
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_fault_reset <= 1'b0;
    end else begin
      cmd_fault_reset <= rx_valid && started && rx_cmd[OUT_FRESET];
    end
  end

  // ==========================================================================
  // Programmable words
  // ==========================================================================
  dioam_param_scan #(
    .NMAP (NMAP)
  ) u_scan (
    .pclk        (pclk),
    .presetn     (presetn),
    .in_map      (in_map),
    .out_map     (out_map),
    .n_words     (n_words),
    .wr_req      (wr_req),
    .wr_data     (wr_words),
    .par_rd_data (par_rd_data),
    .rd_val      (rd_val),
    .par_rd_num  (par_rd_num),
    .par_wr_en   (par_wr_en),
    .par_wr_num  (par_wr_num),
    .par_wr_data (par_wr_data)
  );

endmodule // dioam_top

// ### tb/dioam_monitor.sv
// Assertion checker for the drive I/O assembly mapper
`timescale 1ns/1ps
module dioam_monitor import dioam_pkg::*; #(
  parameter int NMAP = NUM_MAP
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic [2:0]  cfg_layout_select,
  input wire logic        drv_fault,
  input wire logic        drv_alarm,
  input wire logic        drv_turn_fwd,
  input wire logic        drv_turn_rev,
  input wire logic [2:0]  drv_state,
  input wire logic        drv_remote,
  input wire logic        drv_ref_net,
  input wire logic        drv_at_speed,
  input wire logic [15:0] drv_speed_actual,
  input wire logic        rx_valid,
  input wire logic [95:0] rx_data,
  input wire logic [95:0] tx_data,
  input wire logic [2:0]  tx_words,
  input wire logic        cmd_run_fwd,
  input wire logic        cmd_run_rev,
  input wire logic        cmd_fault_reset,
  input wire logic        cmd_remote_control,
  input wire logic        cmd_remote_setpoint,
  input wire logic [15:0] cmd_speed_ref
);
  // ==========================================================================
  // Layout latched once after reset
  logic       st;
  logic [2:0] lay;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st  <= 1'b0;
      lay <= 3'h0;
    end else if (!st) begin
      st  <= 1'b1;
      lay <= (cfg_layout_select > 3'h6) ? 3'h0 : cfg_layout_select;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ==========================================================================
  // Properties
  property p_fault; st |=> tx_data[0] == $past(drv_fault); endproperty
  a_fault: assert property (p_fault) else $error("fault flag wrong");
  property p_ready;
    st && lay != 3'h0 |=> tx_data[4] == ($past(drv_state) inside {3'h3, 3'h4, 3'h5});
  endproperty
  a_ready: assert property (p_ready) else $error("ready flag wrong");
  property p_ext;
    st && lay != 3'h0 |=> tx_data[15:8] == {5'h0, $past(drv_state)}
      && tx_data[7:5] == {$past(drv_at_speed), $past(drv_ref_net), $past(drv_remote)}
      && tx_data[3:0] == {$past(drv_turn_rev), $past(drv_turn_fwd),
                          $past(drv_alarm), $past(drv_fault)};
  endproperty
  a_ext: assert property (p_ext) else $error("extended input");
  property p_basic;
    st && lay == 3'h0 |=> tx_data == {64'h0, $past(drv_speed_actual), 13'h0,
      $past(drv_turn_fwd), 1'b0, $past(drv_fault)};
  endproperty
  a_basic: assert property (p_basic) else $error("basic input wrong");
  property p_cmd;
    st && rx_valid |=> cmd_run_fwd == $past(rx_data[0]) && cmd_speed_ref == $past(rx_data[31:16]);
  endproperty
  a_cmd: assert property (p_cmd) else $error("run or speed command wrong");
  property p_ext_cmd;
    st && rx_valid && lay != 3'h0 |=> cmd_run_rev == $past(rx_data[1])
      && {cmd_remote_setpoint, cmd_remote_control} == $past(rx_data[6:5]);
  endproperty
  a_ext_cmd: assert property (p_ext_cmd) else $error("extended command wrong");
  property p_bas_cmd;
    st && rx_valid && lay == 3'h0 |=> !cmd_run_rev && !cmd_remote_control && !cmd_remote_setpoint;
  endproperty
  a_bas_cmd: assert property (p_bas_cmd) else $error("basic command wrong");
  property p_freset;
    st && rx_valid && rx_data[2] ##1 !rx_valid |-> cmd_fault_reset ##1 !cmd_fault_reset;
  endproperty
  a_freset: assert property (p_freset) else $error("fault reset pulse wrong");
  property p_words; st |=> tx_words == ((lay < 3'h2) ? 3'h2 : lay); endproperty
  a_words: assert property (p_words) else $error("word count wrong");
endmodule // dioam_monitor

bind dioam_top dioam_monitor #(.NMAP(NMAP)) u_mon (
  .pclk(pclk), .presetn(presetn), .cfg_layout_select(cfg_layout_select),
  .drv_fault(drv_fault), .drv_alarm(drv_alarm), .drv_turn_fwd(drv_turn_fwd),
  .drv_turn_rev(drv_turn_rev), .drv_state(drv_state), .drv_remote(drv_remote),
  .drv_ref_net(drv_ref_net), .drv_at_speed(drv_at_speed),
  .drv_speed_actual(drv_speed_actual), .rx_valid(rx_valid), .rx_data(rx_data),
  .tx_data(tx_data), .tx_words(tx_words), .cmd_run_fwd(cmd_run_fwd),
  .cmd_run_rev(cmd_run_rev), .cmd_fault_reset(cmd_fault_reset),
  .cmd_remote_control(cmd_remote_control), .cmd_remote_setpoint(cmd_remote_setpoint),
  .cmd_speed_ref(cmd_speed_ref)
);

// ### tb/dioam_net_master.sv
// Network master model that sends output assemblies
`timescale 1ns/1ps
module dioam_net_master (
  input wire logic        pclk,
  output logic            rx_valid,
  output logic     [95:0] rx_data
);
  initial begin
    rx_valid = 1'b0;
    rx_data  = 96'h0;
  end

  // Command byte, unused byte 1, speed reference, then extra words
  function automatic logic [95:0] frame(input logic [7:0] b0, input logic [15:0] spd,
                                        input logic [63:0] ext);
    return {ext, spd, 8'h00, b0};
  endfunction

  task automatic send(input logic [95:0] f);
    @(posedge pclk);
    rx_valid <= 1'b1;
    rx_data  <= f;
    @(posedge pclk);
    rx_valid <= 1'b0;
    rx_data  <= ~f;
  endtask
endmodule // dioam_net_master

// ### tb/tb_top.sv
// Self-checking testbench for the drive I/O assembly mapper
`timescale 1ns/1ps
module tb_top import dioam_pkg::*;;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic [2:0]  cfg_layout_select, drv_state, tx_words;
  logic        drv_fault, drv_alarm, drv_turn_fwd, drv_turn_rev;
  logic        drv_remote, drv_ref_net, drv_at_speed, rx_valid;
  logic [15:0] drv_speed_actual, cmd_speed_ref, par_rd_data, par_wr_data;
  logic [95:0] rx_data, tx_data;
  logic        cmd_run_fwd, cmd_run_rev, cmd_fault_reset, cmd_remote_control;
  logic        cmd_remote_setpoint, par_wr_en;
  logic [9:0]  par_rd_num, par_wr_num;
  logic [20:0] cmds;
  int          fail_count, check_count;

  initial pclk = 1'b0;
  always #12.5 pclk = ~pclk;
  // Parameter store: value tells its number
  assign par_rd_data = {6'h2a, par_rd_num};
  // Command outputs gathered for compact checks
  assign cmds = {cmd_remote_setpoint, cmd_remote_control, cmd_fault_reset,
                 cmd_run_rev, cmd_run_fwd, cmd_speed_ref};

  dioam_top u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cfg_layout_select(cfg_layout_select), .drv_fault(drv_fault), .drv_alarm(drv_alarm),
    .drv_turn_fwd(drv_turn_fwd), .drv_turn_rev(drv_turn_rev), .drv_state(drv_state),
    .drv_remote(drv_remote), .drv_ref_net(drv_ref_net), .drv_at_speed(drv_at_speed),
    .drv_speed_actual(drv_speed_actual), .rx_valid(rx_valid), .rx_data(rx_data),
    .tx_data(tx_data), .tx_words(tx_words), .cmd_run_fwd(cmd_run_fwd),
    .cmd_run_rev(cmd_run_rev), .cmd_fault_reset(cmd_fault_reset),
    .cmd_remote_control(cmd_remote_control), .cmd_remote_setpoint(cmd_remote_setpoint),
    .cmd_speed_ref(cmd_speed_ref), .par_rd_num(par_rd_num), .par_rd_data(par_rd_data),
    .par_wr_en(par_wr_en), .par_wr_num(par_wr_num), .par_wr_data(par_wr_data));

  dioam_net_master u_net (.pclk(pclk), .rx_valid(rx_valid), .rx_data(rx_data));

  // ==========================================================================
  // Shared tasks
  task automatic chk(input logic [95:0] got, input logic [95:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic do_reset(input logic [2:0] lay);
    @(posedge pclk);
    presetn           <= 1'b0;
    cfg_layout_select <= lay;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
    @(negedge pclk);
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      fail_count++;
      report_and_stop();
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // ==========================================================================
  // Scenarios
  task automatic t_ext;
    logic       rdy;
    logic [7:0] fl;
    do_reset(3'h1);
    {drv_fault, drv_remote, drv_speed_actual} <= {2'b11, 16'h1234};
    for (int i = 0; i < 8; i++) begin
      @(posedge pclk);
      drv_state    <= 3'(i);
      drv_alarm    <= i[0];
      drv_ref_net  <= i[0];
      drv_turn_fwd <= i[1];
      drv_turn_rev <= ~i[1];
      drv_at_speed <= i[2];
      rdy = (i >= 3) && (i <= 5);
      fl  = {i[2], i[0], 1'b1, rdy, ~i[1], i[1], i[0], 1'b1};
      tick(1);
      chk(tx_data, {80'h1234, 5'h0, 3'(i), fl});
    end
    chk(96'(tx_words), 96'h2);
    u_net.send(u_net.frame(8'hff, 16'hbeef, 64'h0));
    @(negedge pclk);
    chk(96'(cmds), 96'h1fbeef);
    tick(1);
    chk(96'(cmds), 96'h1bbeef);
    u_net.send(u_net.frame(8'h9c, 16'h0, 64'h0));
    @(negedge pclk);
    chk(96'(cmds), 96'h040000);
    $display("extended layout test done");
  endtask

  task automatic t_basic;
    // Out-of-range setting falls back to the basic layout
    do_reset(3'h7);
    tick(2);
    chk(tx_data, {64'h0, 16'h1234, 16'h0005});
    u_net.send(u_net.frame(8'hff, 16'h0102, 64'h0));
    @(negedge pclk);
    chk(96'(cmds), 96'h050102);
    $display("basic layout test done");
  endtask

  task automatic t_vendor;
    logic [31:0] rd;
    logic        er;
    int          n;
    do_reset(3'h6);
    cfg_layout_select <= 3'h1;
    apb(1'b0, OFS_IN_MAP0, 32'h0, rd, er);
    chk(96'({er, rd}), 96'h0);
    apb(1'b1, OFS_IN_MAP0, 32'h3bf, rd, er);
    apb(1'b0, OFS_IN_MAP0, 32'h0, rd, er);
    chk(96'({er, rd}), 96'h3bf);
    apb(1'b1, OFS_IN_MAP0 + MAP_STRIDE, 32'h3c0, rd, er);
    chk(96'(er), 96'h1);
    apb(1'b0, 8'h40, 32'h0, rd, er);
    chk(96'(er), 96'h1);
    apb(1'b1, OFS_OUT_MAP0, 32'h5, rd, er);
    apb(1'b0, OFS_STATUS, 32'h0, rd, er);
    chk(96'(rd[5:0]), 96'h36);
    tick(8);
    chk(tx_data, {48'h0, 16'habbf, 16'h1234, 16'h07e7});
    chk(96'(tx_words), 96'h6);
    u_net.send(u_net.frame(8'h01, 16'h0, 64'h47));
    n = 0;
    while (par_wr_en !== 1'b1 && n < 8) begin
      @(negedge pclk);
      n++;
    end
    chk(96'({par_wr_en, par_wr_num, par_wr_data}), 96'({1'b1, 10'h5, 16'h0047}));
    if (par_wr_en !== 1'b1) report_and_stop();
    $display("vendor layout test done");
  endtask

  task automatic t_short;
    logic [31:0] rd;
    logic        er;
    do_reset(3'h3);
    apb(1'b1, OFS_IN_MAP0, 32'h2, rd, er);
    apb(1'b1, OFS_IN_MAP0 + MAP_STRIDE, 32'h1, rd, er);
    chk(96'(er), 96'h0);
    tick(8);
    chk(tx_data, {48'h0, 16'ha802, 16'h1234, 16'h07e7});
    chk(96'(tx_words), 96'h3);
    $display("short vendor layout test done");
  endtask

  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, cfg_layout_select} = '0;
    {drv_fault, drv_alarm, drv_turn_fwd, drv_turn_rev, drv_state} = '0;
    {drv_remote, drv_ref_net, drv_at_speed, drv_speed_actual} = '0;
    fail_count  = 0;
    check_count = 0;
    t_ext();
    t_basic();
    t_vendor();
    t_short();
    report_and_stop();
  end
endmodule // tb_top
